//--- src/i2cd_params.svh
`ifndef I2CD_PARAMS_SVH
`define I2CD_PARAMS_SVH

// =====================================================
// Register indices (byte address = index * 4)
`define I2CD_IDX_MAIN 6'h00
`define I2CD_IDX_SEC 6'h04
`define I2CD_IDX_IEN_CLR 6'h14
`define I2CD_IDX_IEN_SET 6'h16
`define I2CD_IDX_FLAGS 6'h18
`define I2CD_IDX_STATUS 6'h1A
`define I2CD_IDX_SYNCP 6'h1C
`define I2CD_IDX_ADDRESS 6'h24
`define I2CD_IDX_DATA 6'h28

// =====================================================
// Field positions
`define I2CD_MC_SRST 0
`define I2CD_MC_EN 1
`define I2CD_MC_MODE_LO 2
`define I2CD_MC_RUNSTBY 7
`define I2CD_SC_SMART 8
`define I2CD_SC_QUICK 9
`define I2CD_SC_CMD_LO 16
`define I2CD_SC_ACK_ACTION 18
`define I2CD_ST_BUS_LO 4
`define I2CD_AD_BYTE_COUNT_ENABLE 13
`define I2CD_AD_LEN_LO 16
`define I2CD_F_MB 0
`define I2CD_F_SB 1
`define I2CD_F_BYTE_READY_FLAG 2
`define I2CD_F_ERROR 7

// =====================================================
// Values and reset
`define I2CD_MODE_SLAVE 3'h4
`define I2CD_MODE_MASTER 3'h5
`define I2CD_CMD_RESUME 2'h2
`define I2CD_CMD_STOP 2'h3
`define I2CD_BUS_IDLE 2'h1
`define I2CD_BUS_OWNER 2'h2
`define I2CD_BUS_BUSY 2'h3
`define I2CD_REG_RESET 32'h0000_0000

// =====================================================
// Timing
`define I2CD_CLK_NS 50
`define I2CD_SCL_HALF_NS 5000
`define I2CD_SCL_HALF_CYC ((`I2CD_SCL_HALF_NS + `I2CD_CLK_NS - 1) / `I2CD_CLK_NS)
`define I2CD_SYNC_CYC 3

`endif

//--- src/i2cd_pkg.sv
package i2cd_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } i2cd_bus_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_FRAME, ST_W_ADDR, ST_W_RX, ST_W_TX, ST_W_CMD, ST_STOP
   } i2cd_state_e;

   typedef enum logic [1:0] {OP_BUS, OP_ADDR, OP_DATA} i2cd_op_e;

   typedef struct packed {
      logic enable;
      logic run_stby;
      logic [2:0] mode;
      logic smart;
      logic quick;
      logic ack_act;
      logic [1:0] cmd;
      logic [7:0] irq_en;
      logic [7:0] irq_flag;
      logic [1:0] bus_state;
      logic rxnack;
      logic cfault;
      logic [1:0] cnt_rst;
      logic [1:0] cnt_en;
      logic [1:0] cnt_op;
      logic pend_en;
      i2cd_op_e op;
      logic [31:0] op_val;
      logic [7:0] address;
      logic len_en;
      logic [7:0] len;
      logic [7:0] data;
      logic rx_req;
      logic tx_req;
      i2cd_state_e st;
      logic phase;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic rw;
      logic is_addr;
      logic tx;
      logic ackbit;
      logic [7:0] done;
      logic [7:0] div;
      logic scl_drv;
      logic sda_drv;
      logic scl_d;
      logic sda_d;
      logic [31:0] rdata;
      logic pb_err;
   } i2cd_regs_s;

endpackage : i2cd_pkg

//--- src/i2cd_core.sv
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "i2cd_params.svh"
// Function
// - Quick command flags right after address ack
// - Slave DMA data only after address flag serviced
// - Slave receive request set, dropped on read
// - Slave transmit request set, dropped on write
// - Master: address, count, count-enable written together; slave address write loads the address only
// - Count reached: auto NACK on read, STOP
// - Early NACK on counted write: STOP, fault
// - Master receive request set, dropped on read
// - Master transmit request set, dropped on write
// - Each interrupt source owns a flag
// - Enable set and clear registers, ones only
// - Shared interrupt while flag and enable
// - Master core clock runs idle, standby optional
// - Standby stops master clock after transaction
// - Slave address match wakes from standby
// - Slave drops receptions in standby otherwise
// - Sync pending set at once, cleared after
// - Write to a synced register while its own sync is pending gives bus error
// - Reset and enable writes synced separately
// - Bus state, master address, data share sync
// - Smart mode: data read sends ack action

module i2cd_core (
   input wire logic clk,
   input wire logic rstn,
   input wire i2cd_pkg::i2cd_bus_s bus,
   output logic [31:0] rdata,
   output logic pb_error,
   output logic irq,
   output logic wake,
   output logic core_clk_run,
   input wire logic standby,
   output logic dma_rx_req,
   output logic dma_tx_req,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);

   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   i2cd_pkg::i2cd_regs_s s;
   i2cd_pkg::i2cd_regs_s n;
   logic scl_m;
   logic scl_s;
   logic sda_m;
   logic sda_s;

   // =====================================================
   // Pin synchronisers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
      end
   end

   // =====================================================
   // Next state
   always_comb begin
      logic master;
      logic rise;
      logic fall;
      logic start_c;
      logic stop_c;
      logic last;
      logic go_tx;
      logic go_rx;
      logic go_start;
      logic go_stop;
      logic [7:0] tx_byte;
      logic [7:0] fset;
      logic [7:0] fclr;
      logic soft_reset_done;
      master = (s.mode == `I2CD_MODE_MASTER);
      rise = scl_s & ~s.scl_d;
      fall = ~scl_s & s.scl_d;
      start_c = s.scl_d & scl_s & s.sda_d & ~sda_s;
      stop_c = s.scl_d & scl_s & ~s.sda_d & sda_s;
      last = s.len_en && ((s.done + 8'h01) == s.len);
      go_tx = 1'b0;
      go_rx = 1'b0;
      go_start = 1'b0;
      go_stop = 1'b0;
      tx_byte = s.data;
      fset = 8'h00;
      fclr = 8'h00;
      soft_reset_done = 1'b0;
      n = s;
      n.pb_err = 1'b0;
      n.rdata = `I2CD_REG_RESET;
      n.scl_d = scl_s;
      n.sda_d = sda_s;

      // =====================================================
      // Crossing delay countdown
      if (s.cnt_rst != 2'h0) begin
         n.cnt_rst = s.cnt_rst - 2'h1;
         soft_reset_done = (s.cnt_rst == 2'h1);
      end
      if (s.cnt_en != 2'h0) begin
         n.cnt_en = s.cnt_en - 2'h1;
         if (s.cnt_en == 2'h1) begin
            n.enable = s.pend_en;
            n.bus_state = s.pend_en ? `I2CD_BUS_IDLE : 2'h0;
         end
      end
      if (s.cnt_op != 2'h0) begin
         n.cnt_op = s.cnt_op - 2'h1;
         if (s.cnt_op == 2'h1) begin
            case (s.op)
               i2cd_pkg::OP_BUS: n.bus_state = s.op_val[`I2CD_ST_BUS_LO +: 2];
               i2cd_pkg::OP_ADDR: begin
                  n.address = s.op_val[7:0];
                  n.len_en = s.op_val[`I2CD_AD_BYTE_COUNT_ENABLE];
                  n.len = s.op_val[`I2CD_AD_LEN_LO +: 8];
                  go_start = s.enable;
               end
               default: begin
                  n.data = s.op_val[7:0];
                  tx_byte = s.op_val[7:0];
                  go_tx = (s.st == i2cd_pkg::ST_W_TX);
               end
            endcase
         end
      end

      // =====================================================
      // Line engine
      if (stop_c) begin
         if (!master && s.st != i2cd_pkg::ST_IDLE) begin
            fset[`I2CD_F_MB] = 1'b1;
            n.st = i2cd_pkg::ST_IDLE;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
         end
         if (master && s.st == i2cd_pkg::ST_IDLE) begin
            n.bus_state = `I2CD_BUS_IDLE;
         end
      end else if (start_c && master && s.st == i2cd_pkg::ST_IDLE) begin
         n.bus_state = `I2CD_BUS_BUSY;
      end else if (start_c && !master && s.enable && !(standby && !s.run_stby)) begin
         n.st = i2cd_pkg::ST_FRAME;
         n.is_addr = 1'b1;
         n.tx = 1'b0;
         n.bitcnt = 4'h0;
         n.scl_drv = 1'b0;
         n.sda_drv = 1'b0;
      end else begin
         case (s.st)
            i2cd_pkg::ST_START: begin
               if (s.div != 8'h00) begin
                  n.div = s.div - 8'h01;
               end else if (!s.phase && scl_s && sda_s) begin
                  n.sda_drv = 1'b1;
                  n.phase = 1'b1;
                  n.div = 8'(`I2CD_SCL_HALF_CYC);
               end else if (s.phase) begin
                  n.st = i2cd_pkg::ST_FRAME;
                  n.scl_drv = 1'b1;
                  n.div = 8'(`I2CD_SCL_HALF_CYC);
                  n.bus_state = `I2CD_BUS_OWNER;
               end
            end
            i2cd_pkg::ST_STOP: begin
               if (s.div != 8'h00) begin
                  n.div = s.div - 8'h01;
               end else if (!s.phase) begin
                  n.scl_drv = 1'b0;
                  n.phase = 1'b1;
                  n.div = 8'(`I2CD_SCL_HALF_CYC);
               end else if (scl_s) begin
                  n.sda_drv = 1'b0;
                  n.st = i2cd_pkg::ST_IDLE;
                  n.bus_state = `I2CD_BUS_IDLE;
               end
            end
            i2cd_pkg::ST_FRAME: begin
               if (master) begin
                  if (s.div != 8'h00) begin
                     n.div = s.div - 8'h01;
                  end else if (s.scl_drv) begin
                     n.scl_drv = 1'b0;
                     n.div = 8'(`I2CD_SCL_HALF_CYC);
                  end else if (scl_s) begin
                     n.scl_drv = 1'b1;
                     n.div = 8'(`I2CD_SCL_HALF_CYC);
                  end
               end
               if (rise) begin
                  n.bitcnt = s.bitcnt + 4'h1;
                  if (s.bitcnt < 4'h8) begin
                     n.shreg = {s.shreg[6:0], sda_s};
                  end else begin
                     n.ackbit = sda_s;
                  end
               end else if (fall && s.bitcnt < 4'h8) begin
                  n.sda_drv = s.tx & ~s.shreg[7];
               end else if (fall && s.bitcnt == 4'h8) begin
                  if (s.tx) begin
                     n.sda_drv = 1'b0;
                  end else if (s.is_addr) begin
                     n.sda_drv = (s.shreg[7:1] == s.address[7:1]);
                     n.rw = s.shreg[0];
                     if (s.shreg[7:1] != s.address[7:1]) begin
                        n.st = i2cd_pkg::ST_IDLE;
                     end
                  end else begin
                     n.data = s.shreg;
                     n.rx_req = 1'b1;
                     fset[master ? `I2CD_F_SB : `I2CD_F_BYTE_READY_FLAG] = 1'b1;
                     n.st = i2cd_pkg::ST_W_RX;
                     n.scl_drv = 1'b1;
                  end
               end else if (fall) begin
                  n.bitcnt = 4'h0;
                  n.sda_drv = 1'b0;
                  n.is_addr = 1'b0;
                  if (master && s.tx) begin
                     n.done = s.is_addr ? 8'h00 : s.done + 8'h01;
                     n.rxnack = s.ackbit;
                     if (s.ackbit && !s.is_addr && s.len_en && !last) begin
                        n.cfault = 1'b1;
                        fset[`I2CD_F_ERROR] = 1'b1;
                        go_stop = 1'b1;
                     end else if (s.len_en && (s.is_addr ? s.len == 8'h00 : last)) begin
                        go_stop = 1'b1;
                     end else if (s.ackbit || (s.is_addr && s.quick)) begin
                        fset[(s.rw && !s.ackbit) ? `I2CD_F_SB : `I2CD_F_MB] = 1'b1;
                        n.st = i2cd_pkg::ST_W_CMD;
                     end else if (s.is_addr && s.rw) begin
                        n.tx = 1'b0;
                     end else begin
                        n.tx_req = 1'b1;
                        fset[`I2CD_F_MB] = 1'b1;
                        n.st = i2cd_pkg::ST_W_TX;
                     end
                  end else if (master) begin
                     n.done = s.done + 8'h01;
                     if (last) begin
                        go_stop = 1'b1;
                     end else if (!s.sda_drv) begin
                        n.st = i2cd_pkg::ST_W_CMD;
                     end
                  end else if (s.is_addr) begin
                     fset[`I2CD_F_SB] = 1'b1;
                     n.st = i2cd_pkg::ST_W_ADDR;
                     n.scl_drv = 1'b1;
                  end else if (s.tx) begin
                     fset[`I2CD_F_BYTE_READY_FLAG] = 1'b1;
                     if (s.ackbit) begin
                        n.st = i2cd_pkg::ST_IDLE;
                     end else begin
                        n.tx_req = 1'b1;
                        n.st = i2cd_pkg::ST_W_TX;
                        n.scl_drv = 1'b1;
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // =====================================================
      // Register bus
      if (bus.rd) begin
         case (bus.addr)
            {`I2CD_IDX_MAIN, 2'b00}: n.rdata = {24'h0, s.run_stby, 2'b00, s.mode, s.enable, 1'b0};
            {`I2CD_IDX_SEC, 2'b00}: n.rdata = {13'h0, s.ack_act, s.cmd, 6'h0, s.quick, s.smart, 8'h0};
            {`I2CD_IDX_IEN_CLR, 2'b00}: n.rdata = {24'h0, s.irq_en};
            {`I2CD_IDX_IEN_SET, 2'b00}: n.rdata = {24'h0, s.irq_en};
            {`I2CD_IDX_FLAGS, 2'b00}: n.rdata = {24'h0, s.irq_flag};
            {`I2CD_IDX_STATUS, 2'b00}: n.rdata = {21'h0, s.cfault, 4'h0, s.bus_state, 1'b0, s.rxnack, 2'b00};
            {`I2CD_IDX_SYNCP, 2'b00}: n.rdata = {29'h0, s.cnt_op != 2'h0, s.cnt_en != 2'h0, s.cnt_rst != 2'h0};
            {`I2CD_IDX_ADDRESS, 2'b00}: n.rdata = {8'h0, s.len, 2'b00, s.len_en, 5'h0, s.address};
            {`I2CD_IDX_DATA, 2'b00}: n.rdata = {24'h0, s.data};
            default: n.rdata = `I2CD_REG_RESET;
         endcase
         if (hit(bus.addr, `I2CD_IDX_DATA)) begin
            n.rx_req = 1'b0;
            go_rx = s.smart && s.st == i2cd_pkg::ST_W_RX;
         end
      end
      if (bus.wr) begin
         if (hit(bus.addr, `I2CD_IDX_MAIN)) begin
            n.run_stby = bus.wdata[`I2CD_MC_RUNSTBY];
            n.mode = bus.wdata[`I2CD_MC_MODE_LO +: 3];
            if (bus.wdata[`I2CD_MC_SRST]) begin
               n.pb_err = (s.cnt_rst != 2'h0);
               n.cnt_rst = (s.cnt_rst != 2'h0) ? s.cnt_rst - 2'h1 : 2'(`I2CD_SYNC_CYC);
            end else if (s.cnt_en != 2'h0) begin
               n.pb_err = 1'b1;
            end else begin
               n.cnt_en = 2'(`I2CD_SYNC_CYC);
               n.pend_en = bus.wdata[`I2CD_MC_EN];
            end
         end
         if (hit(bus.addr, `I2CD_IDX_SEC)) begin
            n.smart = bus.wdata[`I2CD_SC_SMART];
            n.quick = bus.wdata[`I2CD_SC_QUICK];
            n.ack_act = bus.wdata[`I2CD_SC_ACK_ACTION];
            n.cmd = bus.wdata[`I2CD_SC_CMD_LO +: 2];
            if (bus.wdata[`I2CD_SC_CMD_LO +: 2] == `I2CD_CMD_STOP && master && s.st == i2cd_pkg::ST_W_CMD) begin
               go_stop = 1'b1;
            end
            if (bus.wdata[`I2CD_SC_CMD_LO +: 2] == `I2CD_CMD_RESUME && s.st == i2cd_pkg::ST_W_RX) begin
               go_rx = 1'b1;
            end
         end
         if (hit(bus.addr, `I2CD_IDX_IEN_CLR)) begin
            n.irq_en = s.irq_en & ~bus.wdata[7:0];
         end
         if (hit(bus.addr, `I2CD_IDX_IEN_SET)) begin
            n.irq_en = s.irq_en | bus.wdata[7:0];
         end
         if (hit(bus.addr, `I2CD_IDX_FLAGS)) begin
            fclr = bus.wdata[7:0];
            if (bus.wdata[`I2CD_F_SB] && !master && s.st == i2cd_pkg::ST_W_ADDR) begin
               n.st = s.rw ? i2cd_pkg::ST_W_TX : i2cd_pkg::ST_FRAME;
               n.tx_req = s.rw;
               n.tx = 1'b0;
               n.scl_drv = s.rw;
            end
         end
         if (hit(bus.addr, `I2CD_IDX_ADDRESS) && !master) begin
            n.address = bus.wdata[7:0];
         end
         if (hit(bus.addr, `I2CD_IDX_DATA)) begin
            n.tx_req = 1'b0;
            if (!master) begin
               n.data = bus.wdata[7:0];
               tx_byte = bus.wdata[7:0];
               go_tx = (s.st == i2cd_pkg::ST_W_TX);
            end
         end
         if (hit(bus.addr, `I2CD_IDX_STATUS) || (master && (hit(bus.addr, `I2CD_IDX_ADDRESS)
                                                            || hit(bus.addr, `I2CD_IDX_DATA)))) begin
            if (s.cnt_op != 2'h0) begin
               n.pb_err = 1'b1;
            end else begin
               n.cnt_op = 2'(`I2CD_SYNC_CYC);
               n.op_val = bus.wdata;
               n.op = hit(bus.addr, `I2CD_IDX_STATUS) ? i2cd_pkg::OP_BUS :
                      hit(bus.addr, `I2CD_IDX_DATA) ? i2cd_pkg::OP_DATA : i2cd_pkg::OP_ADDR;
            end
         end
      end

      // =====================================================
      // Sequence starts
      if (go_tx) begin
         n.shreg = tx_byte;
         n.sda_drv = ~tx_byte[7];
         n.st = i2cd_pkg::ST_FRAME;
         n.tx = 1'b1;
         n.bitcnt = 4'h0;
         n.scl_drv = master;
         n.div = 8'(`I2CD_SCL_HALF_CYC);
      end
      if (go_rx) begin
         n.sda_drv = ~(s.ack_act | (master && last));
         n.st = i2cd_pkg::ST_FRAME;
         n.scl_drv = master;
         n.div = 8'(`I2CD_SCL_HALF_CYC);
      end
      if (go_stop) begin
         n.st = i2cd_pkg::ST_STOP;
         n.sda_drv = 1'b1;
         n.scl_drv = 1'b1;
         n.phase = 1'b0;
         n.div = 8'(`I2CD_SCL_HALF_CYC);
      end
      if (go_start) begin
         n.st = i2cd_pkg::ST_START;
         n.shreg = s.op_val[7:0];
         n.rw = s.op_val[0];
         n.is_addr = 1'b1;
         n.tx = 1'b1;
         n.bitcnt = 4'h0;
         n.done = 8'h00;
         n.rxnack = 1'b0;
         n.cfault = 1'b0;
         n.phase = 1'b0;
         n.scl_drv = 1'b0;
         n.sda_drv = 1'b0;
         n.div = 8'(`I2CD_SCL_HALF_CYC);
      end
      // A flag raised in the cycle of its clear survives
      n.irq_flag = (s.irq_flag & ~fclr) | fset;
      if (!n.enable) begin
         n.st = i2cd_pkg::ST_IDLE;
         n.scl_drv = 1'b0;
         n.sda_drv = 1'b0;
      end
      if (soft_reset_done) begin
         n = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // =====================================================
   // Outputs
   assign rdata = s.rdata;
   assign pb_error = s.pb_err;
   assign irq = |(s.irq_flag & s.irq_en);
   // Slave needs the core clock in standby only to catch an address
   assign wake = standby && s.run_stby && s.mode == `I2CD_MODE_SLAVE
                 && s.irq_flag[`I2CD_F_SB] && s.irq_en[`I2CD_F_SB];
   assign core_clk_run = !standby || s.run_stby
                         || (s.mode == `I2CD_MODE_MASTER && s.st != i2cd_pkg::ST_IDLE);
   assign dma_rx_req = s.rx_req;
   assign dma_tx_req = s.tx_req;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = s.scl_drv;
   assign sda_oe = s.sda_drv;

endmodule : i2cd_core

//--- tb/i2cd_asserts.sv
`timescale 1ns/100ps
module i2cd_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire i2cd_pkg::i2cd_bus_s bus,
   input wire logic [31:0] rdata,
   input wire logic pb_error,
   input wire logic irq,
   input wire logic core_clk_run,
   input wire logic standby,
   input wire logic dma_rx_req,
   input wire logic dma_tx_req
);
   // ==========
   // Shadows of the enable mask and master mode, rebuilt from bus writes
   logic [7:0] en_m;
   logic mst;
   logic [7:0] next_en_m;
   logic wd;
   assign wd = bus.wr && bus.addr == 8'hA0;
   always_comb begin
      next_en_m = en_m;
      if (bus.wr && bus.addr == 8'h58) next_en_m = en_m | bus.wdata[7:0];
      if (bus.wr && bus.addr == 8'h50) next_en_m = en_m & ~bus.wdata[7:0];
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) {mst, en_m} <= 9'h000;
      else {mst, en_m} <= {(bus.wr && bus.addr == 8'h00) ? bus.wdata[4:2] == 3'h5 : mst, next_en_m};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // Properties
   property p_tx_drop; dma_tx_req && wd |=> !dma_tx_req; endproperty
   property p_rx_drop; dma_rx_req && bus.rd && bus.addr == 8'hA0 |=> !dma_rx_req; endproperty
   property p_tx_hold; dma_tx_req && !wd |=> dma_tx_req; endproperty
   property p_pend_err; bus.wr && bus.addr == 8'h00 && bus.wdata[1] && !bus.wdata[0]
      ##1 bus.wr && bus.addr == 8'h00 && !bus.wdata[0] |=> pb_error;
   endproperty
   property p_sys_err; mst && bus.wr && bus.addr == 8'h90 ##1 wd |=> pb_error; endproperty
   property p_pend_rd; bus.wr && bus.addr == 8'h00 && bus.wdata[1] && !bus.wdata[0]
      ##1 bus.rd && bus.addr == 8'h70 |=> rdata[1];
   endproperty
   property p_err_src; pb_error |-> $past(bus.wr); endproperty
   property p_irq_mask; en_m == 8'h00 |-> !irq; endproperty
   property p_clk_run; !standby |-> core_clk_run; endproperty
   a_tx_drop: assert property (p_tx_drop) else $error("tx request held after data write");
   a_rx_drop: assert property (p_rx_drop) else $error("rx request held after data read");
   a_tx_hold: assert property (p_tx_hold) else $error("tx request dropped without write");
   a_pend_err: assert property (p_pend_err) else $error("no bus error on pending write");
   a_sys_err: assert property (p_sys_err) else $error("no bus error on pending data write");
   a_pend_rd: assert property (p_pend_rd) else $error("enable pending bit not set");
   a_err_src: assert property (p_err_src) else $error("bus error without write");
   a_irq_mask: assert property (p_irq_mask) else $error("irq with all sources disabled");
   a_clk_run: assert property (p_clk_run) else $error("core clock stopped while awake");
   c_tx: cover property ($rose(dma_tx_req));
   c_rx: cover property ($rose(dma_rx_req));
   c_err: cover property (pb_error);
endmodule : i2cd_asserts

bind i2cd_core i2cd_asserts chk_i (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .pb_error(pb_error),
   .irq(irq), .core_clk_run(core_clk_run), .standby(standby), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req));

//--- tb/i2cd_peer.sv
`timescale 1ns/100ps
module i2cd_peer (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack_data,
   input wire logic [7:0] tx_byte,
   output logic sda_oe,
   output logic [7:0] got,
   output logic ack9
);
   // ==========
   // Target on the wire; one data byte per read, no stretching
   int b = 0;
   int nb = 0;
   logic rd = 1'b0;
   logic [7:0] sh = 8'h00;
   initial sda_oe = 1'b0;
   always @(negedge sda) if (scl === 1'b1) begin
      b = 0;
      nb = 0;
   end
   always @(posedge scl) begin
      if (b < 8) sh = {sh[6:0], sda};
      if (b == 8 && nb == 1) ack9 = sda;
      b++;
   end
   always @(negedge scl) begin
      if (b == 9) begin
         b = 0;
         nb++;
      end
      if (b == 8 && nb == 0) rd = sh[0];
      if (b == 8 && nb == 1) got = sh;
      if (b == 8) sda_oe = (nb == 0) || (!rd && !nack_data);
      else sda_oe = rd && nb == 1 && !tx_byte[7 - b];
   end
endmodule : i2cd_peer

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic standby = 1'b0;
   logic nack_data = 1'b0;
   i2cd_pkg::i2cd_bus_s bus = '0;
   logic [31:0] rdata, v;
   logic pb_error, irq, wake, core_clk_run, dma_rx_req, dma_tx_req;
   logic scl_out, scl_oe, sda_out, sda_oe, p_oe, p_ack;
   logic [7:0] p_got;
   // Open-drain lines with pull-ups
   wire logic scl = !scl_oe;
   wire logic sda = !(sda_oe || p_oe);
   int fails = 0;
   int num_checks = 0;
   int stops = 0;
   i2cd_core uut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .pb_error(pb_error), .irq(irq), .wake(wake),
      .core_clk_run(core_clk_run), .standby(standby), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req),
      .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   i2cd_peer peer (.scl(scl), .sda(sda), .nack_data(nack_data), .tx_byte(8'h5A), .sda_oe(p_oe), .got(p_got),
      .ack9(p_ack));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge sda) if (scl === 1'b1) stops++;
   // ==========
   // Bus cycles and checks
   task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
      @(posedge clk);
      bus <= '{a, d, w, r};
   endtask : op
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      op(a, d, 1'b1, 1'b0);
      op(8'h00, 32'h0, 1'b0, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      op(a, 32'h0, 1'b0, 1'b1);
      op(8'h00, 32'h0, 1'b0, 1'b0);
      #1 v = rdata;
   endtask : rd
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask : chk
   // A whole byte takes about 1800 cycles, so the bound is generous
   task automatic wait_on(input int s, input int t);
      for (int n = 0; n < 30000; n++) begin
         #1;
         if ((s == 0 && dma_tx_req === 1'b1) || (s == 1 && dma_rx_req === 1'b1) || (s == 2 && stops >= t)
             || (s == 3 && irq === 1'b1)) return;
         @(posedge clk);
      end
      fails++;
      report_and_stop();
   endtask : wait_on
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   // ==========
   // Scenarios
   task automatic t_regs();
      logic [7:0] ad [8];
      ad = '{8'h00, 8'h10, 8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'hFC};
      foreach (ad[i]) begin
         rd(ad[i]);
         chk("reset value", 32'h0, v);
      end
   endtask : t_regs
   task automatic t_sync();
      op(8'h00, 32'h16, 1'b1, 1'b0);
      op(8'h00, 32'h16, 1'b1, 1'b0);
      op(8'h70, 32'h0, 1'b0, 1'b1);
      #1 chk("refused write", 32'h1, {31'h0, pb_error});
      op(8'h00, 32'h0, 1'b0, 1'b0);
      #1 chk("sync pending", 32'h2, rdata);
      repeat (4) @(posedge clk);
      rd(8'h70);
      chk("sync done", 32'h0, v);
      rd(8'h00);
      chk("main control", 32'h16, v);
   endtask : t_sync
   task automatic t_irq();
      wr(8'h58, 32'h87);
      rd(8'h50);
      chk("enable set", 32'h87, v);
      wr(8'h50, 32'h86);
      wr(8'h58, 32'h0);
      rd(8'h58);
      chk("enable clear", 32'h01, v);
   endtask : t_irq
   task automatic t_mwrite();
      int s;
      s = stops;
      op(8'h90, 32'h0001_20A0, 1'b1, 1'b0);
      op(8'hA0, 32'hFF, 1'b1, 1'b0);
      op(8'h00, 32'h0, 1'b0, 1'b0);
      #1 chk("data write refused", 32'h1, {31'h0, pb_error});
      wait_on(0, 0);
      chk("irq on flag", 32'h1, {31'h0, irq});
      wr(8'hA0, 32'h3C);
      #1 chk("tx request drop", 32'h0, {31'h0, dma_tx_req});
      wait_on(2, s + 1);
      chk("byte on line", 32'h3C, {24'h0, p_got});
      wr(8'h60, 32'h01);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
   endtask : t_mwrite
   task automatic t_nack();
      int s;
      s = stops;
      nack_data = 1'b1;
      wr(8'h90, 32'h0002_20A0);
      wait_on(0, 0);
      wr(8'hA0, 32'h55);
      wait_on(2, s + 1);
      nack_data = 1'b0;
      rd(8'h68);
      chk("count fault", 32'h400, v & 32'h400);
      rd(8'h60);
      chk("error flag", 32'h80, v & 32'h80);
      wr(8'h60, 32'h87);
   endtask : t_nack
   task automatic t_mread();
      int s;
      s = stops;
      wr(8'h90, 32'h0001_20A1);
      wait_on(1, 0);
      rd(8'hA0);
      chk("read byte", 32'h5A, v);
      chk("rx request drop", 32'h0, {31'h0, dma_rx_req});
      wait_on(2, s + 1);
      chk("nack on last byte", 32'h1, {31'h0, p_ack});
   endtask : t_mread
   task automatic t_quick();
      int s;
      s = stops;
      wr(8'h10, 32'h300);
      wr(8'h90, 32'hA0);
      wait_on(3, 0);
      rd(8'h60);
      chk("quick flag", 32'h1, v & 32'h1);
      wr(8'h10, 32'h3_0300);
      wait_on(2, s + 1);
      wr(8'h60, 32'h3);
   endtask : t_quick
   task automatic t_standby();
      @(posedge clk);
      standby <= 1'b1;
      @(posedge clk);
      #1 chk("clock stopped", 32'h0, {31'h0, core_clk_run});
      wr(8'h00, 32'h96);
      #1 chk("clock in standby", 32'h1, {31'h0, core_clk_run});
      @(posedge clk);
      standby <= 1'b0;
   endtask : t_standby
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      wr(8'h10, 32'h100);
      t_sync();
      t_irq();
      t_mwrite();
      t_nack();
      t_mread();
      t_quick();
      t_standby();
      report_and_stop();
   end
endmodule : tb
